// file: sms_pkg.sv
// sms_pkg: constants and types of the spi master/slave port
package sms_pkg;

	// ----------------------------------------
	// register addresses on the sfr bus
	// ----------------------------------------
	localparam logic [7:0] SMS_ADDR_STATUS = 8'h84;
	localparam logic [7:0] SMS_ADDR_CONTROL = 8'h85;
	localparam logic [7:0] SMS_ADDR_DATA = 8'h86;
	localparam logic [7:0] SMS_ADDR_AUX1 = 8'ha2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] SMS_CONTROL_RST = 8'h04;
	localparam logic [7:0] SMS_STATUS_RST = 8'h00;
	localparam logic [7:0] SMS_DATA_RST = 8'h00;
	localparam logic [7:0] SMS_AUX1_RST = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SMS_CTL_SEL_IGNORE = 7;
	localparam int SMS_CTL_ENABLE = 6;
	localparam int SMS_CTL_ORDER = 5;
	localparam int SMS_CTL_MASTER = 4;
	localparam int SMS_CTL_POL = 3;
	localparam int SMS_CTL_PHASE = 2;
	localparam int SMS_ST_DONE = 7;
	localparam int SMS_ST_WRITE_COLLISION_FLAG = 6;
	localparam int SMS_ST_RATE2 = 0;
	localparam int SMS_AUX_RELOC = 5;

	// ----------------------------------------
	// cycle counts and rate codes
	// ----------------------------------------
	localparam logic [3:0] SMS_LAST_BIT = 4'h7;
	localparam logic [4:0] SMS_LAST_EDGE = 5'h0f;
	localparam logic [6:0] SMS_OVF_PER_HALF = 7'h03;
	localparam logic [2:0] SMS_RATE_UART = 3'h6;
	localparam logic [2:0] SMS_RATE_TIMER = 3'h7;

	typedef enum logic [1:0] {
		SMS_IDLE = 2'h0,
		SMS_RUN = 2'h1,
		SMS_DONE = 2'h3
	} sms_state_t;

	// system clock cycles (or overflow pulses) per half bit
	function automatic logic [6:0] sms_half(input logic [2:0] code);
		case (code)
			3'h0: sms_half = 7'h02;
			3'h1: sms_half = 7'h04;
			3'h2: sms_half = 7'h08;
			3'h3: sms_half = 7'h10;
			3'h4: sms_half = 7'h20;
			3'h5: sms_half = 7'h40;
			default: sms_half = SMS_OVF_PER_HALF;
		endcase
	endfunction : sms_half

endpackage : sms_pkg

// file: sms_spi_partner.sv
// sms_spi_partner: behavioural spi slave standing on the far pins
module sms_spi_partner (
	input wire logic ssn_in, // select, low active
	input wire logic sclk_in, // bit clock
	input wire logic mosi_in, // data in
	input wire logic pol_in, // idle clock level
	input wire logic pha_in, // clock phase
	input wire logic lsb_in, // lsb first
	input wire logic [7:0] tx_in, // byte sent back
	output logic miso_out, // data out
	output logic [7:0] rx_out // byte taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] lead_n = 3'h0, trail_n = 3'h0, idx, smp;
	logic last = 1'b0;
	// counts wrap per byte, so select may stay low across bytes
	assign idx = pha_in ? lead_n - 3'h1 : trail_n;
	assign smp = pha_in ? trail_n : lead_n;
	// released line shows the inverse of its last bit, never a safe 0
	assign miso_out = ssn_in ? ~last : tx_in[lsb_in ? idx : 3'h7 - idx];
	initial rx_out = 8'h00;
	always @(negedge ssn_in) begin
		lead_n = 3'h0;
		trail_n = 3'h0;
	end
	// a leading edge leaves the idle level, a trailing one returns
	always @(sclk_in) begin
		if (!ssn_in) begin
			if ((sclk_in != pol_in) != pha_in)
				rx_out[lsb_in ? smp : 3'h7 - smp] = mosi_in;
			if (sclk_in != pol_in)
				lead_n = lead_n + 3'h1;
			else
				trail_n = trail_n + 3'h1;
			last = miso_out;
		end
	end
endmodule : sms_spi_partner

// file: sms_spi_port.sv
// sms_spi_port: spi master/slave engine behind four sfr registers

module sms_spi_port
	import sms_pkg::*;
(
	input wire logic CLK_IN, // system clock, 25 mhz
	input wire logic RST_N_IN, // synchronous reset, active low
	input wire logic [7:0] SFR_ADDR_IN, // sfr address
	input wire logic SFR_WR_IN, // sfr write strobe
	input wire logic SFR_RD_IN, // sfr read strobe
	input wire logic [7:0] SFR_WDATA_IN, // sfr write data
	output logic [7:0] SFR_RDATA_OUT, // read data, one cycle later
	input wire logic UART_BAUD_OVF_IN, // uart baud overflow pulse
	input wire logic TIMER_OVF_IN, // timer overflow pulse
	input wire logic [1:0] SSN_IN, // slave_select_n level per set
	input wire logic [1:0] SCLK_IN, // bit clock level per set
	input wire logic [1:0] MOSI_IN, // mosi level per set
	input wire logic [1:0] MISO_IN, // miso level per set
	output logic [1:0] SCLK_OUT, // bit clock drive per set
	output logic [1:0] SCLK_OE_N_OUT, // bit clock enable, low drives
	output logic [1:0] MOSI_OUT, // mosi drive per set
	output logic [1:0] MOSI_OE_N_OUT, // mosi enable, low drives
	output logic [1:0] MISO_OUT, // miso drive per set
	output logic [1:0] MISO_OE_N_OUT, // miso enable, low drives
	output logic [1:0] PINS_OWNED_OUT, // pin set taken by the engine
	output logic TX_READY_OUT, // holding register empty
	output logic DONE_IRQ_OUT // done flag, level
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] aux;
		logic done;
		logic write_collision_flag;
		logic rate2;
		logic [7:0] transmit_holding_reg;
		logic thr_full;
		logic [7:0] osr;
		logic osr_full;
		logic [7:0] rx;
		sms_state_t st;
		logic [4:0] edge_cnt;
		logic [6:0] div_cnt;
		logic sclk;
		logic out_bit;
		logic [3:0] bit_cnt;
		logic sclk_prev;
		logic [7:0] rdata;
		logic [1:0] sclk_o;
		logic [1:0] sclk_oe_n;
		logic [1:0] mosi_o;
		logic [1:0] mosi_oe_n;
		logic [1:0] miso_o;
		logic [1:0] miso_oe_n;
		logic [1:0] owned;
	} sms_regs_t;

	sms_regs_t q;
	sms_regs_t d;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// pick the bit that leaves the shifter next
	function automatic logic out_of(input logic [7:0] sr,
			input logic lsb_first);
		out_of = lsb_first ? sr[0] : sr[7];
	endfunction : out_of

	// shift the sampled bit into the far end
	function automatic logic [7:0] shift_in(input logic [7:0] sr,
			input logic b, input logic lsb_first);
		shift_in = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
	endfunction : shift_in

	// level of the selected pin set
	function automatic logic pin_of(input logic [1:0] v,
			input logic sel);
		pin_of = sel ? v[1] : v[0];
	endfunction : pin_of

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic en;
	logic select_ignore;
	logic lsb_first;
	logic clock_polarity;
	logic clock_phase;
	logic reloc;
	logic ssn_in;
	logic sclk_in;
	logic mosi_in;
	logic miso_in;
	logic [2:0] rate;
	logic step;
	logic tick;
	logic leading;
	logic pin_rise;
	logic pin_fall;
	logic slave_lead;
	logic slave_trail;
	logic selected;
	logic busy;
	logic drv_m;
	logic drv_s;

	always_comb begin
		d = q;
		en = q.ctrl[SMS_CTL_ENABLE];
		select_ignore = q.ctrl[SMS_CTL_SEL_IGNORE];
		lsb_first = q.ctrl[SMS_CTL_ORDER];
		clock_polarity = q.ctrl[SMS_CTL_POL];
		clock_phase = q.ctrl[SMS_CTL_PHASE];
		reloc = q.aux[SMS_AUX_RELOC];
		ssn_in = pin_of(SSN_IN, reloc);
		sclk_in = pin_of(SCLK_IN, reloc);
		mosi_in = pin_of(MOSI_IN, reloc);
		miso_in = pin_of(MISO_IN, reloc);
		rate = {q.rate2, q.ctrl[1:0]};
		step = 1'b0;
		tick = 1'b0;
		leading = 1'b0;
		pin_rise = sclk_in & ~q.sclk_prev;
		pin_fall = ~sclk_in & q.sclk_prev;
		slave_lead = clock_polarity ? pin_fall : pin_rise;
		slave_trail = clock_polarity ? pin_rise : pin_fall;
		selected = select_ignore | ~ssn_in;
		busy = (q.st != SMS_IDLE) | q.osr_full | (q.bit_cnt != 4'h0);
		drv_m = 1'b0;
		drv_s = 1'b0;
		d.sclk_prev = sclk_in;

		// holding register drops into an empty shifter between bytes
		if (!q.osr_full && q.thr_full && q.st == SMS_IDLE &&
				q.bit_cnt == 4'h0) begin
			d.osr = q.transmit_holding_reg;
			d.osr_full = 1'b1;
			d.thr_full = 1'b0;
		end

		// software writes; hardware sets below take priority
		if (SFR_WR_IN) begin
			if (SFR_ADDR_IN == SMS_ADDR_CONTROL) begin
				d.ctrl = SFR_WDATA_IN;
			end else if (SFR_ADDR_IN == SMS_ADDR_STATUS) begin
				d.rate2 = SFR_WDATA_IN[SMS_ST_RATE2];
				if (SFR_WDATA_IN[SMS_ST_DONE]) begin
					d.done = 1'b0;
				end
				if (SFR_WDATA_IN[SMS_ST_WRITE_COLLISION_FLAG]) begin
					d.write_collision_flag = 1'b0;
				end
			end else if (SFR_ADDR_IN == SMS_ADDR_DATA) begin
				if (q.thr_full) begin
					d.write_collision_flag = 1'b1;
				end else begin
					d.transmit_holding_reg = SFR_WDATA_IN;
					d.thr_full = 1'b1;
				end
			end else if (SFR_ADDR_IN == SMS_ADDR_AUX1) begin
				d.aux = SFR_WDATA_IN;
			end
		end

		// master clock generator and shifter
		if (!en || !q.ctrl[SMS_CTL_MASTER]) begin
			d.st = SMS_IDLE;
			d.sclk = clock_polarity;
			d.div_cnt = 7'h00;
		end else begin
			case (q.st)
				SMS_IDLE: begin
					d.sclk = clock_polarity;
					if (q.osr_full) begin
						d.st = SMS_RUN;
						d.edge_cnt = 5'h00;
						d.div_cnt = 7'h00;
						if (!clock_phase) begin
							d.out_bit = out_of(q.osr, lsb_first);
						end
					end
				end
				SMS_RUN: begin
					// overflow codes count pulses, the others count clocks
					if (rate == SMS_RATE_UART) begin
						step = UART_BAUD_OVF_IN;
					end else if (rate == SMS_RATE_TIMER) begin
						step = TIMER_OVF_IN;
					end else begin
						step = 1'b1;
					end
					if (step) begin
						if (q.div_cnt == sms_half(rate) - 7'h01) begin
							tick = 1'b1;
							d.div_cnt = 7'h00;
						end else begin
							d.div_cnt = q.div_cnt + 7'h01;
						end
					end
					if (tick) begin
						leading = ~q.edge_cnt[0];
						d.sclk = ~q.sclk;
						d.edge_cnt = q.edge_cnt + 5'h01;
						if (leading == clock_phase) begin
							// launch edge
							if (q.edge_cnt != SMS_LAST_EDGE) begin
								d.out_bit = out_of(q.osr, lsb_first);
							end
						end else begin
							d.osr = shift_in(q.osr, miso_in, lsb_first);
						end
						if (q.edge_cnt == SMS_LAST_EDGE) begin
							d.st = SMS_DONE;
						end
					end
				end
				SMS_DONE: begin
					d.rx = q.osr;
					d.osr_full = 1'b0;
					d.done = 1'b1;
					d.st = SMS_IDLE;
				end
				default: begin
					d.st = SMS_IDLE;
				end
			endcase
		end

		// slave shifter, clocked by the far master's edges
		if (!en || q.ctrl[SMS_CTL_MASTER] || !selected) begin
			d.bit_cnt = 4'h0;
		end else begin
			if (q.bit_cnt == 4'h0 && !clock_phase) begin
				d.out_bit = out_of(q.osr, lsb_first);
			end
			if ((slave_lead && clock_phase) || (slave_trail && !clock_phase)) begin
				d.out_bit = out_of(q.osr, lsb_first);
			end
			if ((slave_lead && !clock_phase) || (slave_trail && clock_phase)) begin
				d.osr = shift_in(q.osr, mosi_in, lsb_first);
				d.bit_cnt = q.bit_cnt + 4'h1;
				if (q.bit_cnt == SMS_LAST_BIT) begin
					d.rx = shift_in(q.osr, mosi_in, lsb_first);
					d.osr_full = 1'b0;
					d.done = 1'b1;
					d.bit_cnt = 4'h0;
				end
			end
		end

		// another master pulls select low: step down to slave
		if (en && !select_ignore && q.ctrl[SMS_CTL_MASTER] && !ssn_in) begin
			d.ctrl[SMS_CTL_MASTER] = 1'b0;
			d.done = 1'b1;
			d.st = SMS_IDLE;
			d.sclk = clock_polarity;
		end

		// read data is registered, so it appears one cycle after the strobe
		if (SFR_RD_IN) begin
			if (SFR_ADDR_IN == SMS_ADDR_CONTROL) begin
				d.rdata = q.ctrl;
			end else if (SFR_ADDR_IN == SMS_ADDR_STATUS) begin
				// mode fault and reserved bits read zero
				d.rdata = {q.done, q.write_collision_flag, q.thr_full, busy,
					3'h0, q.rate2};
			end else if (SFR_ADDR_IN == SMS_ADDR_DATA) begin
				d.rdata = q.rx;
			end else if (SFR_ADDR_IN == SMS_ADDR_AUX1) begin
				d.rdata = q.aux;
			end else begin
				d.rdata = 8'h00;
			end
		end

		// pin drivers; an idle master with ignore 0 floats to avoid contention
		drv_m = d.ctrl[SMS_CTL_ENABLE] & d.ctrl[SMS_CTL_MASTER] &
			(d.ctrl[SMS_CTL_SEL_IGNORE] | (d.st != SMS_IDLE));
		drv_s = d.ctrl[SMS_CTL_ENABLE] & ~d.ctrl[SMS_CTL_MASTER] &
			selected;
		for (int i = 0; i < 2; i++) begin
			d.owned[i] = d.ctrl[SMS_CTL_ENABLE] &
				(d.aux[SMS_AUX_RELOC] == i[0]);
			d.sclk_o[i] = d.sclk;
			d.mosi_o[i] = d.out_bit;
			d.miso_o[i] = d.out_bit;
			d.sclk_oe_n[i] = ~(drv_m & d.owned[i]);
			d.mosi_oe_n[i] = ~(drv_m & d.owned[i]);
			d.miso_oe_n[i] = ~(drv_s & d.owned[i]);
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			q <= '0;
			q.ctrl <= SMS_CONTROL_RST;
			q.aux <= SMS_AUX1_RST;
			q.rx <= SMS_DATA_RST;
			q.rdata <= SMS_STATUS_RST;
			q.st <= SMS_IDLE;
			q.sclk_oe_n <= 2'h3;
			q.mosi_oe_n <= 2'h3;
			q.miso_oe_n <= 2'h3;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign SFR_RDATA_OUT = q.rdata;
	assign SCLK_OUT = q.sclk_o;
	assign SCLK_OE_N_OUT = q.sclk_oe_n;
	assign MOSI_OUT = q.mosi_o;
	assign MOSI_OE_N_OUT = q.mosi_oe_n;
	assign MISO_OUT = q.miso_o;
	assign MISO_OE_N_OUT = q.miso_oe_n;
	assign PINS_OWNED_OUT = q.owned;
	assign TX_READY_OUT = ~q.thr_full;
	assign DONE_IRQ_OUT = q.done;

endmodule : sms_spi_port

// file: sms_spi_port_properties.sv
// sms_spi_port_properties: port-level assertions for the spi engine
module sms_spi_port_properties
	import sms_pkg::*;
(
	input wire logic CLK_IN, // clock
	input wire logic RST_N_IN, // reset, low
	input wire logic [7:0] SFR_ADDR_IN, // address
	input wire logic SFR_WR_IN, // write strobe
	input wire logic SFR_RD_IN, // read strobe
	input wire logic [7:0] SFR_WDATA_IN, // write data
	input wire logic [7:0] SFR_RDATA_OUT, // read data
	input wire logic [1:0] PINS_OWNED_OUT, // owned sets
	input wire logic TX_READY_OUT, // holding empty
	input wire logic DONE_IRQ_OUT // done flag
);
	// ----------------------------------------
	// decode and assertions
	// ----------------------------------------
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire wr_st = SFR_WR_IN && SFR_ADDR_IN == SMS_ADDR_STATUS;
	wire wr_dat = SFR_WR_IN && SFR_ADDR_IN == SMS_ADDR_DATA;
	wire wr_ctl = SFR_WR_IN && SFR_ADDR_IN == SMS_ADDR_CONTROL;
	chk_reset_state: assert property (
		$rose(RST_N_IN) |-> TX_READY_OUT && !DONE_IRQ_OUT && !PINS_OWNED_OUT)
		else $error("outputs wrong after reset");
	chk_hold_fills: assert property (
		wr_dat && TX_READY_OUT |-> ##[1:2] !TX_READY_OUT)
		else $error("holding register not reported full");
	chk_done_sticky: assert property (
		DONE_IRQ_OUT && !wr_st && !$past(wr_st) |=> DONE_IRQ_OUT)
		else $error("done flag dropped by itself");
	chk_done_clear: assert property (
		wr_st && SFR_WDATA_IN[SMS_ST_DONE] && DONE_IRQ_OUT && TX_READY_OUT
		|-> ##[1:2] !DONE_IRQ_OUT) else $error("done flag not cleared");
	chk_zero_keeps: assert property (
		wr_st && !SFR_WDATA_IN[SMS_ST_DONE] && DONE_IRQ_OUT
		|=> DONE_IRQ_OUT [*2]) else $error("zero write cleared done");
	chk_rdata_holds: assert property (
		!SFR_RD_IN |=> $stable(SFR_RDATA_OUT))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (
		SFR_RD_IN && !(SFR_ADDR_IN inside {8'h84, 8'h85, 8'h86, 8'ha2})
		|=> SFR_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
	chk_pins_freed: assert property (
		wr_ctl && !SFR_WDATA_IN[SMS_CTL_ENABLE] |-> ##[1:2] !PINS_OWNED_OUT)
		else $error("pins kept while disabled");
	cover property ($rose(DONE_IRQ_OUT));
	cover property ($fell(TX_READY_OUT));
	cover property ($rose(PINS_OWNED_OUT[1]));
endmodule : sms_spi_port_properties

bind sms_spi_port sms_spi_port_properties sms_spi_port_properties_inst (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SFR_ADDR_IN(SFR_ADDR_IN),
	.SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
	.SFR_RDATA_OUT(SFR_RDATA_OUT), .PINS_OWNED_OUT(PINS_OWNED_OUT),
	.TX_READY_OUT(TX_READY_OUT), .DONE_IRQ_OUT(DONE_IRQ_OUT));

// file: test_spi_master_slave_port.sv
// test_spi_master_slave_port: self-checking bench of the spi engine
module test_spi_master_slave_port
	import sms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, wr, rd, uovf, tovf, p_ssn, pol, pha, lsb, sel, p_miso;
	logic tx_ready, done;
	logic [7:0] addr, wdata, rdata, p_tx, p_rx;
	logic [1:0] ssn, sclk_i, mosi_i, miso_i, sclk_o, sclk_oe_n, mosi_o;
	logic [1:0] mosi_oe_n, miso_o, miso_oe_n, owned, far_miso;
	int fail_count = 0, samples_checked = 0, ovf_cnt = 0;
	// released pins: clock rests idle, mosi pulled up, miso from partner
	assign sclk_i = (sclk_oe_n & {2{pol}}) | (~sclk_oe_n & sclk_o);
	assign mosi_i = mosi_oe_n | mosi_o;
	assign far_miso = sel ? {p_miso, 1'b1} : {1'b1, p_miso};
	assign miso_i = (miso_oe_n & far_miso) | (~miso_oe_n & miso_o);
	sms_spi_port sms_spi_port_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
		.SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_RD_IN(rd),
		.SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .UART_BAUD_OVF_IN(uovf),
		.TIMER_OVF_IN(tovf), .SSN_IN(ssn), .SCLK_IN(sclk_i), .MOSI_IN(mosi_i),
		.MISO_IN(miso_i), .SCLK_OUT(sclk_o), .SCLK_OE_N_OUT(sclk_oe_n),
		.MOSI_OUT(mosi_o), .MOSI_OE_N_OUT(mosi_oe_n), .MISO_OUT(miso_o),
		.MISO_OE_N_OUT(miso_oe_n), .PINS_OWNED_OUT(owned),
		.TX_READY_OUT(tx_ready), .DONE_IRQ_OUT(done));
	sms_spi_partner sms_spi_partner_inst (.ssn_in(p_ssn),
		.sclk_in(sclk_i[sel]), .mosi_in(mosi_i[sel]), .pol_in(pol),
		.pha_in(pha), .lsb_in(lsb), .tx_in(p_tx), .miso_out(p_miso),
		.rx_out(p_rx));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// overflow sources run free at two periods, 4 and 5 cycles
	always @(posedge clk) begin
		#1 ovf_cnt++;
		uovf = ovf_cnt % 4 == 0;
		tovf = ovf_cnt % 5 == 0;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1 addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1 rd = 1'b0;
		check(rdata, exp);
	endtask : rd_chk
	// bounded wait; the count doubles as a measure of transfer length
	task automatic wait_hi(ref logic s, output int n);
		n = 0;
		while (s !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
		// a wait that runs out is a hang, so it counts against the run
		if (s !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: wait timed out", $time);
		end
	endtask : wait_hi
	task automatic end_sim();
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check({tx_ready, done, owned, 4'h0}, 8'h80);
		rd_chk(SMS_ADDR_STATUS, 8'h00);
		rd_chk(SMS_ADDR_CONTROL, 8'h04);
		rd_chk(SMS_ADDR_DATA, 8'h00);
		rd_chk(SMS_ADDR_AUX1, 8'h00);
		rd_chk(8'h87, 8'h00);
		wr_reg(SMS_ADDR_STATUS, 8'h0f);
		rd_chk(SMS_ADDR_STATUS, 8'h01);
	endtask : t_reset
	// every rate code once, across every mode, bit order and pin set
	task automatic t_master();
		int n, h, p;
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			sel = i[0];
			pol = i[1];
			pha = i[2];
			lsb = i[0] ^ i[1];
			b = 8'h35 + 8'(i * 29);
			p_tx = ~b;
			h = i < 6 ? 2 << i : (i == 6 ? 12 : 15);
			p = i < 6 ? 0 : h / 3;
			wr_reg(SMS_ADDR_AUX1, {2'h0, sel, 5'h0});
			wr_reg(SMS_ADDR_STATUS, {7'h0, i[2]});
			wr_reg(SMS_ADDR_CONTROL, {2'h3, lsb, 1'b1, pol, pha, i[1:0]});
			// the clock takes its new idle level one cycle after the
			// control write; selecting earlier shows the partner a false edge
			@(posedge clk);
			#1 p_ssn = 1'b0;
			wr_reg(SMS_ADDR_DATA, b);
			wait_hi(done, n);
			check(8'(n >= 16 * h - p && n <= 16 * h + p + 10), 8'h01);
			check({7'h0, sclk_o[sel]}, {7'h0, pol});
			check(p_rx, b);
			rd_chk(SMS_ADDR_DATA, ~b);
			check({6'h0, owned}, {6'h0, sel, ~sel});
			wr_reg(SMS_ADDR_STATUS, {1'b1, 6'h0, i[2]});
			rd_chk(SMS_ADDR_STATUS, {7'h0, i[2]});
			p_ssn = 1'b1;
		end
	endtask : t_master
	task automatic t_collide();
		int n;
		{sel, pol, pha, lsb, p_tx} = {4'h2, 8'h5a};
		wr_reg(SMS_ADDR_AUX1, 8'h00);
		wr_reg(SMS_ADDR_CONTROL, 8'hd5);
		// wait for the idle level to settle before selecting the partner
		@(posedge clk);
		#1 p_ssn = 1'b0;
		wr_reg(SMS_ADDR_DATA, 8'hc3);
		wait_hi(tx_ready, n);
		rd_chk(SMS_ADDR_STATUS, 8'h11);
		wr_reg(SMS_ADDR_DATA, 8'h3c);
		wr_reg(SMS_ADDR_DATA, 8'hff);
		rd_chk(SMS_ADDR_STATUS, 8'h71);
		check({7'h0, tx_ready}, 8'h00);
		wr_reg(SMS_ADDR_STATUS, 8'h41);
		rd_chk(SMS_ADDR_STATUS, 8'h31);
		wait_hi(done, n);
		wr_reg(SMS_ADDR_STATUS, 8'h81);
		rd_chk(SMS_ADDR_STATUS, 8'h11);
		wait_hi(done, n);
		check(p_rx, 8'h3c);
		rd_chk(SMS_ADDR_STATUS, 8'h81);
		p_ssn = 1'b1;
	endtask : t_collide
	task automatic t_mode();
		int n;
		wr_reg(SMS_ADDR_STATUS, 8'h80);
		wr_reg(SMS_ADDR_CONTROL, 8'h50);
		ssn = 2'b10;
		wait_hi(done, n);
		check({7'h0, done}, 8'h01);
		rd_chk(SMS_ADDR_CONTROL, 8'h40);
		check({6'h0, miso_oe_n}, 8'h02);
		wr_reg(SMS_ADDR_STATUS, 8'h00);
		check({7'h0, done}, 8'h01);
		ssn = 2'b11;
		wr_reg(SMS_ADDR_CONTROL, 8'h04);
		rd_chk(SMS_ADDR_CONTROL, 8'h04);
		check({2'h0, sclk_oe_n, mosi_oe_n, miso_oe_n}, 8'h3f);
		check({6'h0, owned}, 8'h00);
	endtask : t_mode
	// slave byte, phase 1: the bench plays master through the idle level
	// of the released clock pin; mosi floats high, so 0xff comes in
	task automatic t_slave();
		logic [7:0] got;
		got = 8'h00;
		wr_reg(SMS_ADDR_STATUS, 8'hc0);
		wr_reg(SMS_ADDR_CONTROL, 8'h44);
		wr_reg(SMS_ADDR_DATA, 8'ha6);
		ssn = 2'b10;
		for (int k = 0; k < 8; k++) begin
			repeat (4) @(posedge clk);
			#1 pol = 1'b1;
			repeat (4) @(posedge clk);
			#1 got[7 - k] = miso_o[0];
			pol = 1'b0;
		end
		check(got, 8'ha6);
		check({6'h0, miso_oe_n}, 8'h02);
		rd_chk(SMS_ADDR_DATA, 8'hff);
		rd_chk(SMS_ADDR_STATUS, 8'h80);
		ssn = 2'b11;
	endtask : t_slave
	initial begin
		{rst_n, wr, rd, uovf, tovf, pol, pha, lsb, sel} = 9'h0;
		{addr, wdata, p_tx, ssn, p_ssn} = {24'h0, 3'h7};
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_master();
		t_collide();
		t_mode();
		t_slave();
		end_sim();
	end
	// watchdog: the whole run needs well under 10000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		end_sim();
	end
endmodule : test_spi_master_slave_port
